// ---- hdl/alnum_regs.vh ----
`ifndef ALNUM_REGS_VH
`define ALNUM_REGS_VH

// Register offsets (byte addresses)
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_INT_STAT 8'h08
`define OFF_INT_MASK 8'h0C

// Control fields
`define CTRL_DISP_EN_BIT 0
`define CTRL_RESET 1'h1

// Status fields
`define ST_LOC_LSB 0
`define ST_FULL_BIT 4
`define ST_POS_LSB 5
`define ST_STANDBY_BIT 8
`define ST_MODE_BIT 9

// Interrupt bits
`define IRQ_FULL_BIT 0
`define IRQ_WIPE_BIT 1
`define IRQ_WRITE_BIT 2
`define IRQ_W 3
`define IRQ_MASK_RESET 3'h0

// Character memory
`define MEM_DEPTH 8
`define MEM_AW 3
`define CODE_W 6
`define WIPE_CODE 6'h20
`define SEG_W 17

// Timing: 400 Hz frame over eight characters
`define CLK_PERIOD_NS 4
`define SLOT_TIME_NS 312500
`define BLANK_TIME_NS 1000
`define SCAN_CNT_W 17

`endif

// ---- hdl/char_mem.v ----
`timescale 1ns/1ns
`include "alnum_regs.vh"

module char_mem #(
    parameter DEPTH = `MEM_DEPTH,
    parameter AW = `MEM_AW,
    parameter DW = `CODE_W
) (
    input wire i_mclk, // Core clock
    input wire i_rst_n, // Async reset, active low
    input wire i_wipe, // Erase every entry
    input wire i_wr_en, // Write strobe, one cycle
    input wire [AW-1:0] i_wr_addr, // Write location
    input wire [DW-1:0] i_wr_data, // Write code
    input wire [AW-1:0] i_rd_addr, // Read location
    output reg [DW-1:0] o_rd_data_ff // Registered read code
);

    wire [DW*DEPTH-1:0] flat;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : gen_entry
            reg [DW-1:0] entry_ff;
            always @(posedge i_mclk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    entry_ff <= `WIPE_CODE;
                else if (i_wipe)
                    entry_ff <= `WIPE_CODE;
                else if (i_wr_en && (i_wr_addr == g))
                    entry_ff <= i_wr_data;
            end
            assign flat[g*DW +: DW] = entry_ff;
        end
    endgenerate

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rd_data_ff <= `WIPE_CODE;
        else
            o_rd_data_ff <= flat[i_rd_addr*DW +: DW];
    end

endmodule

// ---- hdl/char_font.v ----
`timescale 1ns/1ns
`include "alnum_regs.vh"

module char_font (
    input wire i_mclk, // Core clock
    input wire i_rst_n, // Async reset, active low
    input wire [5:0] i_code, // Six-bit character code
    output reg [16:0] o_seg_ff // Bit 16 decimal point, 15:0 segments
);

    reg [16:0] nxt_seg;

    // Mask-style table; 14-segment parts simply leave the split halves tied
    always @*
    begin
        case (i_code)
            6'h00: nxt_seg = 17'h0A3F7; 6'h01: nxt_seg = 17'h088CF;
            6'h02: nxt_seg = 17'h02A3F; 6'h03: nxt_seg = 17'h000F3;
            6'h04: nxt_seg = 17'h0223F; 6'h05: nxt_seg = 17'h080F3;
            6'h06: nxt_seg = 17'h080C3; 6'h07: nxt_seg = 17'h008FB;
            6'h08: nxt_seg = 17'h088CC; 6'h09: nxt_seg = 17'h02233;
            6'h0A: nxt_seg = 17'h0007C; 6'h0B: nxt_seg = 17'h094C0;
            6'h0C: nxt_seg = 17'h000F0; 6'h0D: nxt_seg = 17'h005CC;
            6'h0E: nxt_seg = 17'h011CC; 6'h0F: nxt_seg = 17'h000FF;
            6'h10: nxt_seg = 17'h088C7; 6'h11: nxt_seg = 17'h010FF;
            6'h12: nxt_seg = 17'h098C7; 6'h13: nxt_seg = 17'h088BB;
            6'h14: nxt_seg = 17'h02203; 6'h15: nxt_seg = 17'h000FC;
            6'h16: nxt_seg = 17'h044C0; 6'h17: nxt_seg = 17'h050CC;
            6'h18: nxt_seg = 17'h05500; 6'h19: nxt_seg = 17'h08884;
            6'h1A: nxt_seg = 17'h04433; 6'h1B: nxt_seg = 17'h02212;
            6'h1C: nxt_seg = 17'h01100; 6'h1D: nxt_seg = 17'h02221;
            6'h1E: nxt_seg = 17'h05000; 6'h1F: nxt_seg = 17'h00030;
            6'h20: nxt_seg = 17'h00000; 6'h21: nxt_seg = 17'h1000C;
            6'h22: nxt_seg = 17'h00204; 6'h23: nxt_seg = 17'h0AA3C;
            6'h24: nxt_seg = 17'h0AABB; 6'h25: nxt_seg = 17'h0EE99;
            6'h26: nxt_seg = 17'h09371; 6'h27: nxt_seg = 17'h00200;
            6'h28: nxt_seg = 17'h01400; 6'h29: nxt_seg = 17'h04100;
            6'h2A: nxt_seg = 17'h0FF00; 6'h2B: nxt_seg = 17'h0AA00;
            6'h2C: nxt_seg = 17'h04000; 6'h2D: nxt_seg = 17'h08800;
            6'h2E: nxt_seg = 17'h10000; 6'h2F: nxt_seg = 17'h04400;
            6'h30: nxt_seg = 17'h044FF; 6'h31: nxt_seg = 17'h0040C;
            6'h32: nxt_seg = 17'h08877; 6'h33: nxt_seg = 17'h0083F;
            6'h34: nxt_seg = 17'h0888C; 6'h35: nxt_seg = 17'h090B3;
            6'h36: nxt_seg = 17'h088FB; 6'h37: nxt_seg = 17'h0000F;
            6'h38: nxt_seg = 17'h088FF; 6'h39: nxt_seg = 17'h088BF;
            6'h3A: nxt_seg = 17'h02200; 6'h3B: nxt_seg = 17'h04200;
            6'h3C: nxt_seg = 17'h09400; 6'h3D: nxt_seg = 17'h08830;
            6'h3E: nxt_seg = 17'h04900; 6'h3F: nxt_seg = 17'h12807;
            default: nxt_seg = 17'h00000;
        endcase
    end

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_seg_ff <= 17'h00000;
        else
            o_seg_ff <= nxt_seg;
    end

endmodule

// ---- hdl/alnum_display_controller.v ----
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "alnum_regs.vh"

// Summary of operation
// - Eight six-bit entries hold codes taken straight from the host data pins.
// - Each stored code passes a 64-entry font table to 16 segments plus point.
// - Mode pin high means sequential entry, low means addressed entry.
// - First sequential write after a wipe lands in location zero, leftmost.
// - Later sequential writes go one location higher, counter advancing until it reaches eight.
// - Full flag rises once eight sequential entries are stored, for cascading.
// - Wipe erases all entries and returns the location counter to zero.
// - Addressed writes store at the supplied three-bit location.
// - Scan runs continuously except in standby or while a host write is in progress.
// - Scan enables the character driver matching the location being decoded.
// - All segments blank briefly between successive character positions.
// - Standby turns the display off and parks the scan.
// - In sequential mode a low location bit 1 pin wipes counter, memory and display.
// - Shared pin is address MSB in addressed mode, full output in sequential.
module alnum_display_controller #(
    parameter SLOT_CYC = `SLOT_TIME_NS / `CLK_PERIOD_NS,
    parameter BLANK_CYC = (`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input wire i_mclk, // Core clock, 250 MHz
    input wire i_rst_n, // Async reset, active low
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire i_pwrite, // APB direction
    input wire [7:0] i_paddr, // APB byte address
    input wire [31:0] i_pwdata, // APB write data
    output reg [31:0] o_prdata, // APB read data
    output wire o_pready, // APB ready
    output wire o_pslverr, // APB error on unmapped address
    input wire [5:0] i_data, // Character code pins
    input wire i_cs_n, // Chip select, active low
    input wire i_cs, // Chip select, active high
    input wire i_wr_n, // Write strobe, active low
    input wire i_mode, // High sequential, low addressed
    input wire i_addr0, // Location bit 0
    input wire i_addr1_or_wipe, // Location bit 1, or wipe when low
    input wire i_addr2_or_full_flag, // Shared pin, input side
    output wire o_addr2_or_full_flag, // Shared pin, output side
    output wire o_addr2_or_full_flag_oe, // Shared pin drive enable
    input wire i_oscillator_standby_n, // Low requests standby
    output reg [16:0] o_segments, // Segment drive, bit 16 point
    output reg [7:0] o_char_en, // One-hot character drive
    output wire o_irq // Level interrupt
);

    // Pipeline is address, memory read, font; blank must cover it
    localparam BLANK_EFF = (BLANK_CYC < 3) ? 3 : BLANK_CYC;
    localparam [`SCAN_CNT_W-1:0] SLOT_LAST = SLOT_CYC[`SCAN_CNT_W-1:0] - {{(`SCAN_CNT_W-1){1'b0}}, 1'b1};
    localparam [`SCAN_CNT_W-1:0] BLANK_END = BLANK_EFF[`SCAN_CNT_W-1:0];
    localparam PIN_W = 15;

    localparam SCAN_RUN = 2'b00;
    localparam SCAN_HOLD = 2'b01;
    localparam SCAN_SLEEP = 2'b10;

    // Pin synchronisers
    reg [PIN_W-1:0] pin_meta_ff;
    reg [PIN_W-1:0] pin_sync_ff;
    wire [PIN_W-1:0] pin_raw;

    assign pin_raw = {i_data, i_cs_n, i_cs, i_wr_n, i_mode, i_addr0, i_addr1_or_wipe,
        i_addr2_or_full_flag, i_oscillator_standby_n, 1'b0};

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            // Idle pin levels: no false standby, shared pin not driven in reset
            pin_meta_ff <= 15'h014A;
            pin_sync_ff <= 15'h014A;
        end
        else
        begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    wire [5:0] s_data = pin_sync_ff[14:9];
    wire s_cs_n = pin_sync_ff[8];
    wire s_cs = pin_sync_ff[7];
    wire s_wr_n = pin_sync_ff[6];
    wire s_mode = pin_sync_ff[5];
    wire s_a0 = pin_sync_ff[4];
    wire s_a1 = pin_sync_ff[3];
    wire s_a2 = pin_sync_ff[2];
    wire s_run_n = pin_sync_ff[1];

    // Host write capture
    reg wr_prev_ff;
    reg sel_prev_ff;
    reg [5:0] data_prev_ff;
    reg [2:0] addr_prev_ff;
    reg mode_prev_ff;

    wire selected = ~s_cs_n & s_cs;
    wire write_busy = ~s_wr_n & selected;
    wire wipe = s_mode & ~s_a1;
    wire standby = ~s_run_n;

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_prev_ff <= 1'b1;
            sel_prev_ff <= 1'b0;
            data_prev_ff <= 6'h00;
            addr_prev_ff <= 3'h0;
            mode_prev_ff <= 1'b0;
        end
        else
        begin
            wr_prev_ff <= s_wr_n;
            sel_prev_ff <= selected;
            data_prev_ff <= s_data;
            addr_prev_ff <= {s_a2, s_a1, s_a0};
            mode_prev_ff <= s_mode;
        end
    end

    // Values from the last low cycle survive a zero data hold time
    wire commit = ~wr_prev_ff & s_wr_n & sel_prev_ff & ~wipe;

    // Location counter and full flag
    reg [3:0] loc_ff;
    reg [3:0] nxt_loc;
    reg full_ff;
    reg nxt_full;
    reg mem_wr_en;
    reg [2:0] mem_wr_addr;

    always @*
    begin
        nxt_loc = loc_ff;
        mem_wr_en = 1'b0;
        mem_wr_addr = addr_prev_ff;
        if (wipe)
        begin
            nxt_loc = 4'h0;
        end
        else if (commit && mode_prev_ff)
        begin
            // Writes beyond eight are left for the next cascaded device
            if (loc_ff != 4'h8)
            begin
                mem_wr_en = 1'b1;
                mem_wr_addr = loc_ff[2:0];
                nxt_loc = loc_ff + 4'h1;
            end
        end
        else if (commit)
        begin
            mem_wr_en = 1'b1;
        end
        nxt_full = (nxt_loc == 4'h8);
    end

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            loc_ff <= 4'h0;
            full_ff <= 1'b0;
        end
        else
        begin
            loc_ff <= nxt_loc;
            full_ff <= nxt_full;
        end
    end

    assign o_addr2_or_full_flag = full_ff;
    assign o_addr2_or_full_flag_oe = s_mode;

    // Scan sequencer
    reg [1:0] scan_state_ff;
    reg [1:0] nxt_scan_state;
    reg [`SCAN_CNT_W-1:0] slot_cnt_ff;
    reg [`SCAN_CNT_W-1:0] nxt_slot_cnt;
    reg [2:0] pos_ff;
    reg [2:0] nxt_pos;

    always @*
    begin
        nxt_scan_state = scan_state_ff;
        nxt_slot_cnt = slot_cnt_ff;
        nxt_pos = pos_ff;
        case (scan_state_ff)
            SCAN_RUN:
            begin
                if (standby)
                    nxt_scan_state = SCAN_SLEEP;
                else if (write_busy)
                    nxt_scan_state = SCAN_HOLD;
                else if (slot_cnt_ff == SLOT_LAST)
                begin
                    nxt_slot_cnt = {`SCAN_CNT_W{1'b0}};
                    nxt_pos = pos_ff + 3'h1;
                end
                else
                    nxt_slot_cnt = slot_cnt_ff + 1'b1;
            end
            SCAN_HOLD:
            begin
                if (standby)
                    nxt_scan_state = SCAN_SLEEP;
                else if (!write_busy)
                    nxt_scan_state = SCAN_RUN;
            end
            SCAN_SLEEP:
            begin
                nxt_slot_cnt = {`SCAN_CNT_W{1'b0}};
                nxt_pos = 3'h0;
                if (!standby)
                    nxt_scan_state = SCAN_RUN;
            end
            default:
            begin
                nxt_scan_state = SCAN_RUN;
            end
        endcase
    end

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scan_state_ff <= SCAN_RUN;
            slot_cnt_ff <= {`SCAN_CNT_W{1'b0}};
            pos_ff <= 3'h0;
        end
        else
        begin
            scan_state_ff <= nxt_scan_state;
            slot_cnt_ff <= nxt_slot_cnt;
            pos_ff <= nxt_pos;
        end
    end

    // Memory and font
    wire [5:0] rd_code;
    wire [16:0] font_seg;

    char_mem #(
        .DEPTH(`MEM_DEPTH),
        .AW(`MEM_AW),
        .DW(`CODE_W)
    ) u_mem (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_wipe(wipe),
        .i_wr_en(mem_wr_en),
        .i_wr_addr(mem_wr_addr),
        .i_wr_data(data_prev_ff),
        .i_rd_addr(pos_ff),
        .o_rd_data_ff(rd_code)
    );

    char_font u_font (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_code(rd_code),
        .o_seg_ff(font_seg)
    );

    // Display drive
    reg disp_en_ff;
    wire in_blank = (slot_cnt_ff < BLANK_END);
    wire lit = (scan_state_ff != SCAN_SLEEP) & ~standby & disp_en_ff & ~in_blank;

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_segments <= 17'h00000;
            o_char_en <= 8'h00;
        end
        else if (lit)
        begin
            o_segments <= font_seg;
            o_char_en <= 8'h01 << pos_ff;
        end
        else
        begin
            o_segments <= 17'h00000;
            o_char_en <= 8'h00;
        end
    end

    // Interrupt events
    reg wipe_prev_ff;
    reg [`IRQ_W-1:0] int_stat_ff;
    reg [`IRQ_W-1:0] int_mask_ff;
    wire [`IRQ_W-1:0] events;

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wipe_prev_ff <= 1'b0;
        else
            wipe_prev_ff <= wipe;
    end

    assign events = {mem_wr_en, wipe & ~wipe_prev_ff, nxt_full & ~full_ff};
    assign o_irq = |(int_stat_ff & int_mask_ff);

    // APB slave, zero wait states
    wire apb_setup = i_psel & ~i_penable;
    wire apb_wr = i_psel & i_penable & i_pwrite;
    wire mapped = (i_paddr == `OFF_CTRL) | (i_paddr == `OFF_STATUS) |
        (i_paddr == `OFF_INT_STAT) | (i_paddr == `OFF_INT_MASK);
    wire [`IRQ_W-1:0] w1c = (apb_wr && i_paddr == `OFF_INT_STAT) ? i_pwdata[`IRQ_W-1:0] : 3'h0;

    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            disp_en_ff <= `CTRL_RESET;
            int_mask_ff <= `IRQ_MASK_RESET;
            int_stat_ff <= 3'h0;
        end
        else
        begin
            // Set beats a simultaneous clear
            int_stat_ff <= (int_stat_ff & ~w1c) | events;
            if (apb_wr && i_paddr == `OFF_CTRL)
                disp_en_ff <= i_pwdata[`CTRL_DISP_EN_BIT];
            if (apb_wr && i_paddr == `OFF_INT_MASK)
                int_mask_ff <= i_pwdata[`IRQ_W-1:0];
        end
    end

    reg [31:0] nxt_rdata;

    always @*
    begin
        nxt_rdata = 32'h00000000;
        case (i_paddr)
            `OFF_CTRL:
                nxt_rdata[`CTRL_DISP_EN_BIT] = disp_en_ff;
            `OFF_STATUS:
            begin
                nxt_rdata[`ST_LOC_LSB +: 4] = loc_ff;
                nxt_rdata[`ST_FULL_BIT] = full_ff;
                nxt_rdata[`ST_POS_LSB +: 3] = pos_ff;
                nxt_rdata[`ST_STANDBY_BIT] = standby;
                nxt_rdata[`ST_MODE_BIT] = s_mode;
            end
            `OFF_INT_STAT:
                nxt_rdata[`IRQ_W-1:0] = int_stat_ff;
            `OFF_INT_MASK:
                nxt_rdata[`IRQ_W-1:0] = int_mask_ff;
            default:
                nxt_rdata = 32'h00000000;
        endcase
    end

    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_prdata <= 32'h00000000;
        else if (apb_setup && !i_pwrite)
            o_prdata <= nxt_rdata;
    end

endmodule

// ---- sim/alnum_props.sv ----
`timescale 1ns/1ns
module alnum_props #(
    parameter SLOT_CYC = 20,
    parameter BLANK_CYC = 4
) (
    input wire i_mclk, // Clock
    input wire i_rst_n, // Reset
    input wire i_psel, // Select
    input wire i_penable, // Enable
    input wire i_pwrite, // Direction
    input wire [7:0] i_paddr, // Address
    input wire o_pslverr, // Error
    input wire i_cs_n, // Select low
    input wire i_cs, // Select high
    input wire i_wr_n, // Strobe
    input wire i_mode, // Entry mode
    input wire i_addr1_or_wipe, // Wipe pin
    input wire o_addr2_or_full_flag, // Full flag
    input wire o_addr2_or_full_flag_oe, // Flag drive
    input wire i_oscillator_standby_n, // Standby
    input wire [16:0] o_segments, // Segments
    input wire [7:0] o_char_en // Drivers
);
    reg [7:0] last_ff;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    // Forgotten on standby or control write, since both may legally jump the scan
    always @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            last_ff <= 8'h00;
        else if (!i_oscillator_standby_n || (i_psel && i_penable && i_pwrite && i_paddr == 8'h00))
            last_ff <= 8'h00;
        else if (o_char_en != 8'h00)
            last_ff <= o_char_en;
    end
    one_driver_a: assert property ($onehot0(o_char_en))
        else $error("Several character drivers on");
    dark_segments_a: assert property (o_char_en == 8'h00 |-> o_segments == 17'h00000)
        else $error("Segments lit with no driver");
    char_gap_a: assert property ($changed(o_char_en) && o_char_en != 8'h00 |-> $past(o_char_en) == 8'h00)
        else $error("No blank between characters");
    scan_order_a: assert property (o_char_en != 8'h00 && $past(o_char_en) == 8'h00 && last_ff != 8'h00
        |-> o_char_en == {last_ff[6:0], last_ff[7]}) else $error("Scan out of order");
    standby_dark_a: assert property ((!i_oscillator_standby_n) [*4] |-> o_char_en == 8'h00)
        else $error("Display lit in standby");
    scan_hold_a: assert property ((i_cs && !i_cs_n && !i_wr_n) [*6] |=> $stable(o_char_en))
        else $error("Scan moved during write");
    wipe_full_a: assert property ((i_mode && !i_addr1_or_wipe) [*4] |-> !o_addr2_or_full_flag)
        else $error("Full flag during wipe");
    full_hold_a: assert property ((i_cs && !i_cs_n && !i_wr_n && i_addr1_or_wipe) [*2] |=> $stable(o_addr2_or_full_flag))
        else $error("Full flag moved before strobe rose");
    flag_drive_a: assert property ($stable(i_mode) [*4] |-> o_addr2_or_full_flag_oe == i_mode)
        else $error("Shared pin drive wrong for mode");
    bad_addr_a: assert property (i_psel && i_penable && i_paddr[1:0] == 2'b00 |-> o_pslverr == (i_paddr > 8'h0C))
        else $error("Bus error flag wrong");
endmodule

bind alnum_display_controller alnum_props #(.SLOT_CYC(SLOT_CYC), .BLANK_CYC(BLANK_CYC)) u_props (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_pslverr(o_pslverr), .i_cs_n(i_cs_n), .i_cs(i_cs), .i_wr_n(i_wr_n), .i_mode(i_mode),
    .i_addr1_or_wipe(i_addr1_or_wipe), .o_addr2_or_full_flag(o_addr2_or_full_flag),
    .o_addr2_or_full_flag_oe(o_addr2_or_full_flag_oe), .i_oscillator_standby_n(i_oscillator_standby_n),
    .o_segments(o_segments), .o_char_en(o_char_en));

// ---- sim/host_bus_model.sv ----
`timescale 1ns/1ns
module host_bus_model #(
    parameter PW = 64,
    parameter HOLD = 32
) (
    input wire i_mclk, // Clock
    output reg [5:0] o_data, // Code pins
    output reg o_cs_n, // Select low
    output reg o_cs, // Select high
    output reg o_wr_n, // Strobe
    output reg o_mode, // Entry mode
    output reg o_addr0, // Location bit 0
    output reg o_addr1, // Location bit 1 or wipe
    output reg o_addr2 // Location bit 2
);
    // PW covers the 250 ns width and data setup; HOLD the address hold
    initial
    begin
        o_data = 6'h15;
        o_cs_n = 1'b1;
        o_cs = 1'b0;
        o_wr_n = 1'b1;
        o_mode = 1'b1;
        o_addr0 = 1'b0;
        o_addr1 = 1'b1;
        o_addr2 = 1'b0;
    end
    task write_char(input logic m, input logic [2:0] a, input logic [5:0] c, input logic sel);
    begin
        @(posedge i_mclk);
        o_mode <= m;
        o_addr0 <= a[0];
        o_addr1 <= a[1] | m;
        o_addr2 <= a[2];
        o_cs <= sel;
        o_cs_n <= 1'b0;
        o_data <= c;
        repeat (8) @(posedge i_mclk);
        o_wr_n <= 1'b0;
        repeat (PW) @(posedge i_mclk);
        o_wr_n <= 1'b1;
        o_data <= ~c;
        repeat (HOLD) @(posedge i_mclk);
        // Released lines flip so a stale value cannot pass for a held one
        o_addr0 <= ~a[0];
        o_addr2 <= ~a[2];
        o_cs <= 1'b0;
        o_cs_n <= 1'b1;
        repeat (PW) @(posedge i_mclk);
    end
    endtask
    task wipe;
    begin
        @(posedge i_mclk);
        o_mode <= 1'b1;
        o_addr1 <= 1'b0;
        repeat (PW) @(posedge i_mclk);
        o_addr1 <= 1'b1;
        repeat (8) @(posedge i_mclk);
    end
    endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic standby_n = 1'b1;
    wire [31:0] prdata;
    wire pready, pslverr, h_cs_n, h_cs, h_wr_n, h_mode, h_a0, h_a1, h_a2, flag, flag_oe, a2_pin, irq;
    wire [5:0] h_data;
    wire [16:0] segs;
    wire [7:0] char_en;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    logic [16:0] s, s0, blank;
    assign a2_pin = flag_oe ? flag : h_a2;
    always #2 i_mclk = ~i_mclk;

    alnum_display_controller #(.SLOT_CYC(20), .BLANK_CYC(4)) uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_data(h_data), .i_cs_n(h_cs_n), .i_cs(h_cs), .i_wr_n(h_wr_n), .i_mode(h_mode), .i_addr0(h_a0),
        .i_addr1_or_wipe(h_a1), .i_addr2_or_full_flag(a2_pin), .o_addr2_or_full_flag(flag),
        .o_addr2_or_full_flag_oe(flag_oe), .i_oscillator_standby_n(standby_n), .o_segments(segs),
        .o_char_en(char_en), .o_irq(irq));
    host_bus_model hm (
        .i_mclk(i_mclk), .o_data(h_data), .o_cs_n(h_cs_n), .o_cs(h_cs), .o_wr_n(h_wr_n), .o_mode(h_mode),
        .o_addr0(h_a0), .o_addr1(h_a1), .o_addr2(h_a2));

    task end_of_test;
    begin
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge i_mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (pready !== 1'b1)
            @(posedge i_mclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task rreg(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd & m);
    end
    endtask
    // Waits for the position to light; a stuck scan is caught by the cycle ceiling
    task seg_at(input int p);
    begin
        while (char_en !== (8'h01 << p))
            @(posedge i_mclk);
        repeat (2) @(posedge i_mclk);
        s = segs;
    end
    endtask

    always @(posedge i_mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test;
        end
    end

    initial
    begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rreg("ctrl", 8'h00, 32'h1, 32'h1);
        rreg("int_mask", 8'h0C, 32'h7, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        hm.wipe();
        rreg("status", 8'h04, 32'h31F, 32'h200);
        rreg("int_stat", 8'h08, 32'h7, 32'h2);
        apb(1'b1, 8'h08, 32'h7);
        for (int i = 0; i < 9; i++)
        begin
            hm.write_char(1'b1, 3'b010, 6'h01 + i[5:0], 1'b1);
            rreg("status", 8'h04, 32'h31F, (i < 7) ? 32'h201 + i : 32'h218);
        end
        chk("full_flag", 32'h1, {31'h0, flag});
        chk("irq_masked", 32'h0, {31'h0, irq});
        rreg("int_stat", 8'h08, 32'h7, 32'h5);
        apb(1'b1, 8'h0C, 32'h1);
        repeat (2) @(posedge i_mclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, 8'h08, 32'h7);
        repeat (2) @(posedge i_mclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        seg_at(0);
        s0 = s;
        hm.wipe();
        chk("full_wiped", 32'h0, {31'h0, flag});
        rreg("status", 8'h04, 32'h31F, 32'h200);
        seg_at(3);
        blank = s;
        chk("font", 32'h1, {31'h0, s0 !== blank});
        hm.write_char(1'b1, 3'b101, 6'h01, 1'b1);
        seg_at(0);
        chk("pos0", s0, s);
        seg_at(1);
        chk("pos1", blank, s);
        hm.write_char(1'b0, 3'b110, 6'h01, 1'b1);
        hm.write_char(1'b0, 3'b001, 6'h01, 1'b1);
        hm.write_char(1'b0, 3'b011, 6'h01, 1'b0);
        rreg("mode", 8'h04, 32'h200, 32'h0);
        seg_at(6);
        chk("pos6", s0, s);
        seg_at(1);
        chk("pos1", s0, s);
        seg_at(0);
        chk("pos0", s0, s);
        seg_at(3);
        chk("pos3", blank, s);
        standby_n <= 1'b0;
        repeat (40) @(posedge i_mclk);
        chk("standby_dark", 32'h0, {24'h0, char_en});
        rreg("standby", 8'h04, 32'h100, 32'h100);
        standby_n <= 1'b1;
        apb(1'b1, 8'h00, 32'h0);
        repeat (4) @(posedge i_mclk);
        chk("disabled", 32'h0, {24'h0, char_en});
        apb(1'b1, 8'h00, 32'h1);
        seg_at(2);
        chk("pos2", blank, s);
        end_of_test;
    end
endmodule
